// *** shared/codec_timing_consts.svh ***
`ifndef CODEC_TIMING_CONSTS_SVH
`define CODEC_TIMING_CONSTS_SVH

// Clock
`define CLK_PERIOD_PS     8000
`define CLK_FREQ_KHZ      125000

// Bit clock, rounded to the nearest whole divider
`define BIT_CLK_KHZ       772
`define BIT_CLK_CYC       (((`CLK_FREQ_KHZ * 2) / `BIT_CLK_KHZ + 1) / 2)
`define BIT_CLK_HIGH_CYC  (`BIT_CLK_CYC / 2)

// Slot phases in ns
`define ENCODE_NS         9100
`define NONENC_NS         6500
`define SAMPLE_NS         4550
`define HOLD_NS           1950
`define SLOT_CYC          (((`ENCODE_NS + `NONENC_NS) * 1000) / `CLK_PERIOD_PS)
`define SAMPLE_CYC        ((`SAMPLE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define HOLD_CYC          ((`HOLD_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ENCODE_CYC        (`SLOT_CYC - `SAMPLE_CYC - `HOLD_CYC)

// Decoder output settling with the multiplexer open
`define DEC_SETTLE_NS     500
`define DEC_SETTLE_CYC    ((`DEC_SETTLE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// Pattern memory and data path
`define PAT_DEPTH         4
`define PAT_DUR_W         12
`define CODE_W            8
`define CHAN_W            3
`define MAG_BITS          7
`define FIFO_DEPTH        16
`endif

// *** shared/codec_timing_pkg.sv ***
package codec_timing_pkg;

    // Phase controls held in the pattern latch
    typedef struct packed {
        logic sample;
        logic hold;
        logic encode;
    } phase_ctrl_t;

    // One pattern memory word
    typedef struct packed {
        logic        last;
        phase_ctrl_t ctrl;
        logic [11:0] dur;
    } pattern_word_t;

    // Channel number with its eight-bit code
    typedef struct packed {
        logic [2:0] chan;
        logic [7:0] code;
    } chan_word_t;

    typedef enum logic [1:0] {
        D_ON     = 2'b00,
        D_LOAD   = 2'b01,
        D_SETTLE = 2'b10,
        D_ADDR   = 2'b11
    } dec_state_t;

endpackage

// *** hw/shared_codec_timing_controller.sv ***
`timescale 1ns/1ps
`include "codec_timing_consts.svh"

module codec_word_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      wr_d;
    logic [AW:0]      rd_q;
    logic [AW:0]      rd_d;
    logic             push;
    logic             pop;

    // Full and empty from pointer wrap bits
    always_comb
    begin
        in_ready_o  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
        out_valid_o = (wr_q != rd_q);
        out_data_o  = mem_q[rd_q[AW-1:0]];
        push        = in_valid_i && in_ready_o;
        pop         = out_valid_o && out_ready_i;
        wr_d        = push ? wr_q + 1'b1 : wr_q;
        rd_d        = pop ? rd_q + 1'b1 : rd_q;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
endmodule

module shared_codec_timing_controller (
    input  wire logic                           clk_i,
    input  wire logic                           rst_n_i,
    input  wire logic                           comp_i,
    input  wire logic                           pattern_we_i,
    input  wire logic [1:0]                     pattern_addr_i,
    input  wire codec_timing_pkg::pattern_word_t pattern_data_i,
    input  wire logic                           dec_valid_i,
    input  wire codec_timing_pkg::chan_word_t    dec_data_i,
    output logic                                dec_ready_o,
    output logic                                bit_clk_o,
    output logic                                sample_o,
    output logic                                hold_o,
    output logic                                encode_o,
    output logic [2:0]                          enc_chan_o,
    output logic [7:0]                          sar_trial_o,
    output logic                                enc_valid_o,
    output codec_timing_pkg::chan_word_t        enc_data_o,
    output logic [7:0]                          dec_code_o,
    output logic                                dec_load_o,
    output logic [2:0]                          mux_addr_o,
    output logic                                output_switch_enable_lead_o
);
    import codec_timing_pkg::*;

    localparam logic [11:0] BIT_CYC    = 12'(`BIT_CLK_CYC);
    localparam logic [11:0] BIT_HIGH   = 12'(`BIT_CLK_HIGH_CYC);
    localparam logic [6:0]  SETTLE_CYC = 7'(`DEC_SETTLE_CYC);

    // Reset pattern: sample, hold, encode
    localparam pattern_word_t PAT0 = '{1'b0, '{1'b1, 1'b0, 1'b0}, 12'(`SAMPLE_CYC)};
    localparam pattern_word_t PAT1 = '{1'b0, '{1'b0, 1'b1, 1'b0}, 12'(`HOLD_CYC)};
    localparam pattern_word_t PAT2 = '{1'b1, '{1'b0, 1'b1, 1'b1}, 12'(`ENCODE_CYC)};
    localparam pattern_word_t PAT3 = '{1'b1, '{1'b0, 1'b0, 1'b0}, 12'h001};

    // Sets a decided bit and raises the next trial bit
    function automatic logic [7:0] sar_step(input logic [7:0] word, input logic [2:0] pos, input logic keep);
        logic [7:0] w;
        w      = word;
        w[pos] = keep;
        if (pos != 3'h0)
            w[pos - 3'h1] = 1'b1;
        return w;
    endfunction

    pattern_word_t rom_q [`PAT_DEPTH];
    pattern_word_t pat_q;
    pattern_word_t pat_d;
    logic [1:0]    addr_q;
    logic [1:0]    addr_d;
    logic [11:0]   dur_q;
    logic [11:0]   dur_d;
    logic [2:0]    chan_q;
    logic [2:0]    chan_d;
    logic          seg_end;
    logic          slot_end;

    logic          comp_meta_q;
    logic          comp_s_q;
    logic [11:0]   div_q;
    logic [11:0]   div_d;
    logic          bclk_q;
    logic          bclk_d;
    logic          enc_prev_q;
    logic          enc_start;
    logic [3:0]    idx_q;
    logic [3:0]    idx_d;
    logic [7:0]    trial_q;
    logic [7:0]    trial_d;
    logic          env_q;
    logic          env_d;
    chan_word_t    encw_q;
    chan_word_t    encw_d;

    dec_state_t    dst_q;
    dec_state_t    dst_d;
    logic [6:0]    set_q;
    logic [6:0]    set_d;
    logic [7:0]    dcode_q;
    logic [7:0]    dcode_d;
    logic [2:0]    dchan_q;
    logic [2:0]    dchan_d;
    logic [2:0]    maddr_q;
    logic [2:0]    maddr_d;
    logic          men_q;
    logic          men_d;
    logic          dload_q;
    logic          dload_d;
    logic          fifo_valid;
    logic          fifo_pop;
    chan_word_t    fifo_data;

    codec_word_fifo #(
        .WIDTH ($bits(chan_word_t)),
        .DEPTH (`FIFO_DEPTH)
    ) dec_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (dec_valid_i),
        .in_ready_o  (dec_ready_o),
        .in_data_i   (dec_data_i),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_data)
    );

    // Pattern memory, reprogrammable at run time
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rom_q[0] <= PAT0;
            rom_q[1] <= PAT1;
            rom_q[2] <= PAT2;
            rom_q[3] <= PAT3;
        end
        else if (pattern_we_i)
            rom_q[pattern_addr_i] <= pattern_data_i;
    end

    // Address counter walks the memory into the output latch
    always_comb
    begin
        seg_end  = (dur_q <= 12'h001);
        slot_end = seg_end && pat_q.last;
        addr_d   = addr_q;
        pat_d    = pat_q;
        dur_d    = dur_q - 12'h001;
        chan_d   = slot_end ? chan_q + 3'h1 : chan_q;
        if (seg_end)
        begin
            addr_d = pat_q.last ? 2'h0 : addr_q + 2'h1;
            pat_d  = rom_q[addr_d];
            dur_d  = rom_q[addr_d].dur;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            addr_q <= 2'h0;
            pat_q  <= PAT0;
            dur_q  <= PAT0.dur;
            chan_q <= 3'h0;
        end
        else
        begin
            addr_q <= addr_d;
            pat_q  <= pat_d;
            dur_q  <= dur_d;
            chan_q <= chan_d;
        end
    end

    // Comparator pin synchroniser
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            comp_meta_q <= 1'b0;
            comp_s_q    <= 1'b0;
        end
        else
        begin
            comp_meta_q <= comp_i;
            comp_s_q    <= comp_meta_q;
        end
    end

    // Bit clock and successive approximation
    always_comb
    begin
        enc_start = pat_q.ctrl.encode && !enc_prev_q;
        if (enc_start)
            div_d = 12'h001;
        else if (div_q == BIT_CYC - 12'h001)
            div_d = 12'h000;
        else
            div_d = div_q + 12'h001;
        bclk_d  = (div_d < BIT_HIGH);
        idx_d   = idx_q;
        trial_d = trial_q;
        env_d   = 1'b0;
        encw_d  = encw_q;
        if (pat_q.ctrl.sample)
            trial_d = 8'h00;
        if (enc_start)
        begin
            trial_d = sar_step(8'h00, 3'h7, comp_s_q);
            idx_d   = 4'h1;
        end
        else if (pat_q.ctrl.encode && div_q == 12'h000 && idx_q != 4'h0 && idx_q <= 4'(`MAG_BITS))
        begin
            trial_d = sar_step(trial_q, 3'(4'h7 - idx_q), comp_s_q);
            idx_d   = idx_q + 4'h1;
            if (idx_q == 4'(`MAG_BITS))
            begin
                env_d  = 1'b1;
                encw_d = '{chan_q, trial_d};
                idx_d  = 4'h0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            div_q      <= 12'h000;
            bclk_q     <= 1'b0;
            enc_prev_q <= 1'b0;
            idx_q      <= 4'h0;
            trial_q    <= 8'h00;
            env_q      <= 1'b0;
            encw_q     <= '0;
        end
        else
        begin
            div_q      <= div_d;
            bclk_q     <= bclk_d;
            enc_prev_q <= pat_q.ctrl.encode;
            idx_q      <= idx_d;
            trial_q    <= trial_d;
            env_q      <= env_d;
            encw_q     <= encw_d;
        end
    end

    // Decode side multiplexer sequencing
    always_comb
    begin
        dst_d    = dst_q;
        set_d    = set_q;
        dcode_d  = dcode_q;
        dchan_d  = dchan_q;
        maddr_d  = maddr_q;
        men_d    = men_q;
        dload_d  = 1'b0;
        fifo_pop = 1'b0;
        unique case (dst_q)
            D_ON:
            begin
                if (slot_end && fifo_valid)
                begin
                    men_d = 1'b0;
                    dst_d = D_LOAD;
                end
            end
            D_LOAD:
            begin
                fifo_pop = 1'b1;
                dcode_d  = fifo_data.code;
                dchan_d  = fifo_data.chan;
                dload_d  = 1'b1;
                set_d    = SETTLE_CYC;
                dst_d    = D_SETTLE;
            end
            D_SETTLE:
            begin
                set_d = set_q - 7'h01;
                if (set_q == 7'h01)
                begin
                    maddr_d = dchan_q;
                    dst_d   = D_ADDR;
                end
            end
            D_ADDR:
            begin
                men_d = 1'b1;
                dst_d = D_ON;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dst_q   <= D_ON;
            set_q   <= 7'h00;
            dcode_q <= 8'h00;
            dchan_q <= 3'h0;
            maddr_q <= 3'h0;
            men_q   <= 1'b0;
            dload_q <= 1'b0;
        end
        else
        begin
            dst_q   <= dst_d;
            set_q   <= set_d;
            dcode_q <= dcode_d;
            dchan_q <= dchan_d;
            maddr_q <= maddr_d;
            men_q   <= men_d;
            dload_q <= dload_d;
        end
    end

    // Outputs straight from flops
    assign bit_clk_o                   = bclk_q;
    assign sample_o                    = pat_q.ctrl.sample;
    assign hold_o                      = pat_q.ctrl.hold;
    assign encode_o                    = pat_q.ctrl.encode;
    assign enc_chan_o                  = chan_q;
    assign sar_trial_o                 = trial_q;
    assign enc_valid_o                 = env_q;
    assign enc_data_o                  = encw_q;
    assign dec_code_o                  = dcode_q;
    assign dec_load_o                  = dload_q;
    assign mux_addr_o                  = maddr_q;
    assign output_switch_enable_lead_o = men_q;
endmodule

// *** testbench/codec_far_side_model.sv ***
`timescale 1ns/1ps
module codec_far_side_model (
    input  wire logic       encode_i,
    input  wire logic [7:0] trial_i,
    input  wire logic [7:0] level_i,
    output logic            comp_o
);
    // Comparator: held level polarity, then magnitude against the trial word
    always_comb
    begin
        comp_o = encode_i ? (trial_i[6:0] <= level_i[6:0]) : level_i[7];
    end
endmodule

// *** testbench/codec_timing_checker.sv ***
`timescale 1ns/1ps
module codec_timing_checker (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       bit_clk_o,
    input wire logic       sample_o,
    input wire logic       hold_o,
    input wire logic       encode_o,
    input wire logic [7:0] sar_trial_o,
    input wire logic       enc_valid_o,
    input wire logic       dec_load_o,
    input wire logic [2:0] mux_addr_o,
    input wire logic       output_switch_enable_lead_o
);
    logic [11:0] enc_cnt_q, enc_cnt_d, gap_q, gap_d;
    logic        enc_prev_q, clk_prev_q, in_enc_q, in_enc_d, en;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    assign en = output_switch_enable_lead_o;

    // Cycles since encode start and since the last bit clock rise
    always_comb
    begin
        enc_cnt_d = (encode_o && !enc_prev_q) ? 12'h001 : enc_cnt_q + {11'h000, enc_cnt_q != 12'hfff};
        gap_d     = (bit_clk_o && !clk_prev_q) ? 12'h001 : gap_q + {11'h000, gap_q != 12'hfff};
        in_enc_d  = encode_o && (in_enc_q || (bit_clk_o && !clk_prev_q && enc_prev_q));
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            enc_cnt_q  <= 12'hfff;
            gap_q      <= 12'hfff;
            in_enc_q   <= 1'b0;
            enc_prev_q <= 1'b0;
            clk_prev_q <= 1'b0;
        end
        else
        begin
            enc_cnt_q  <= enc_cnt_d;
            gap_q      <= gap_d;
            in_enc_q   <= in_enc_d;
            enc_prev_q <= encode_o;
            clk_prev_q <= bit_clk_o;
        end
    end

    bit_period_a: assert property ($rose(bit_clk_o) && encode_o && in_enc_q |-> gap_q == 12'h0a2)
        else $error("bit clock period wrong");
    enc_done_a: assert property (enc_valid_o |-> enc_cnt_q == 12'h46f)
        else $error("conversion result at wrong cycle");
    enc_pulse_a: assert property (enc_valid_o |=> !enc_valid_o)
        else $error("result strobe longer than one cycle");
    sign_first_a: assert property ($rose(encode_o) |=> sar_trial_o[6:0] == 7'h40)
        else $error("first trial word wrong");
    trial_clear_a: assert property (sample_o && $past(sample_o) |-> sar_trial_o == 8'h00)
        else $error("trial word not clear while sampling");
    hold_order_a: assert property ($rose(encode_o) |-> hold_o && !sample_o)
        else $error("encode began without hold");
    mux_open_a: assert property (dec_load_o |-> !en ##1 (!en && $stable(mux_addr_o))[*8])
        else $error("switch not open while decoder settles");
    fall_first_a: assert property ($fell(en) |=> dec_load_o)
        else $error("decoder load not after switch opened");
    addr_first_a: assert property ($changed(mux_addr_o) |-> !en ##1 en)
        else $error("address change not followed by enable");
    en_return_a: assert property (dec_load_o |-> ##64 $rose(en))
        else $error("switch enable late or early");
endmodule

bind shared_codec_timing_controller codec_timing_checker checker_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .bit_clk_o(bit_clk_o), .sample_o(sample_o), .hold_o(hold_o),
    .encode_o(encode_o), .sar_trial_o(sar_trial_o), .enc_valid_o(enc_valid_o), .dec_load_o(dec_load_o),
    .mux_addr_o(mux_addr_o), .output_switch_enable_lead_o(output_switch_enable_lead_o)
);

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_errors++; \
    $display("unexpected %s: expected %0h seen %0h", nm, ex, got); end end
module testbench;
    import codec_timing_pkg::*;
    logic          clk_i, rst_n_i, comp_i, pattern_we_i, dec_valid_i, dec_ready_o, bit_clk_o;
    logic          sample_o, hold_o, encode_o, enc_valid_o, dec_load_o, output_switch_enable_lead_o;
    logic [1:0]    pattern_addr_i;
    logic [2:0]    enc_chan_o, mux_addr_o, addr_prev;
    logic [2:0]    exp_chan = 3'h0;
    logic [7:0]    sar_trial_o, dec_code_o, level;
    logic [15:0]   lfsr_q, r, er;
    logic          en_prev = 1'b0;
    pattern_word_t pattern_data_i;
    chan_word_t    dec_data_i, enc_data_o, dq[$];
    int            n_errors = 0, checks = 0, n_dec = 0, load_at = 0, cyc = 0;

    shared_codec_timing_controller shared_codec_timing_controller_i (.*);
    codec_far_side_model codec_far_side_model_i (.encode_i(encode_o), .trial_i(sar_trial_o),
        .level_i(level), .comp_o(comp_i));

    // Clock, 8 ns period
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    function automatic logic [15:0] rnd();
        lfsr_q = {1'b0, lfsr_q[15:1]} ^ (lfsr_q[0] ? 16'hb400 : 16'h0000);
        return lfsr_q;
    endfunction

    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Measure one slot: sample, hold and encode spans, bit clock period
    task automatic measure(input int s, input int h);
        int   ns, nh, ne, nr, r1, r2;
        logic pb;
        ns = 0;
        nh = 0;
        ne = 0;
        nr = 0;
        r1 = 0;
        r2 = 0;
        pb = 1'b1;
        while (sample_o !== 1'b0) tick();
        while (sample_o !== 1'b1) tick();
        while (sample_o === 1'b1) begin ns++; tick(); end
        while (encode_o !== 1'b1) begin nh++; tick(); end
        while (encode_o === 1'b1)
        begin
            ne++;
            if (bit_clk_o === 1'b1 && pb === 1'b0) nr++;
            if (bit_clk_o === 1'b1 && pb === 1'b0 && nr == 2) r1 = ne;
            if (bit_clk_o === 1'b1 && pb === 1'b0 && nr == 3) r2 = ne;
            pb = bit_clk_o;
            tick();
        end
        `CHECK("sample cycles", s, ns)
        `CHECK("hold cycles", h, nh)
        `CHECK("encode cycles", 1950 - s - h, ne)
        `CHECK("bit period", 162, r2 - r1)
    endtask

    task automatic put_word(input logic [1:0] a, input pattern_word_t w);
        pattern_we_i   <= 1'b1;
        pattern_addr_i <= a;
        pattern_data_i <= w;
        @(posedge clk_i);
    endtask

    // Hold the word until the buffer takes it; ready is read settled, before the edge
    task automatic push(input chan_word_t w);
        logic taken;
        dec_valid_i <= 1'b1;
        dec_data_i  <= w;
        taken = 1'b0;
        while (!taken)
        begin
            @(negedge clk_i);
            taken = (dec_ready_o === 1'b1);
            @(posedge clk_i);
        end
        dq.push_back(w);
    endtask

    // Encode scoreboard, new held level per slot
    always @(posedge clk_i)
    begin
        #1;
        if (enc_valid_o === 1'b1)
        begin
            `CHECK("encoded word", chan_word_t'({exp_chan, level}), enc_data_o)
            `CHECK("slot channel", exp_chan, enc_chan_o)
            exp_chan = exp_chan + 3'h1;
            er = rnd();
            level = er[7:0];
        end
    end

    // Decode scoreboard
    always @(posedge clk_i)
    begin
        #1;
        cyc++;
        if (dec_load_o === 1'b1)
        begin
            `CHECK("decoder code", dq[0].code, dec_code_o)
            `CHECK("switch open", 1'b0, output_switch_enable_lead_o)
            load_at = cyc;
        end
        if (output_switch_enable_lead_o === 1'b1 && en_prev !== 1'b1)
        begin
            `CHECK("switch address", dq[0].chan, mux_addr_o)
            `CHECK("address before enable", dq[0].chan, addr_prev)
            `CHECK("settle cycles", 64, cyc - load_at)
            void'(dq.pop_front());
            n_dec++;
        end
        en_prev = output_switch_enable_lead_o;
        addr_prev = mux_addr_o;
    end

    initial
    begin
        repeat (45000) @(posedge clk_i);
        n_errors++;
        final_report();
    end

    initial
    begin
        rst_n_i = 1'b0;
        pattern_we_i = 1'b0;
        pattern_addr_i = 2'h0;
        pattern_data_i = '0;
        dec_valid_i = 1'b0;
        dec_data_i = '0;
        lfsr_q = 16'hb0eb;
        r = rnd();
        level = r[7:0];
        repeat (10) @(posedge clk_i);
        `CHECK("reset levels", 5'h11, {sample_o, hold_o, encode_o, output_switch_enable_lead_o, dec_ready_o})
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        for (int i = 0; i < 16; i++)
        begin
            r = rnd();
            push(chan_word_t'(r[10:0]));
        end
        dec_valid_i <= 1'b0;
        #1;
        `CHECK("buffer full", 1'b0, dec_ready_o)
        @(posedge clk_i);
        r = rnd();
        push(chan_word_t'(r[10:0]));
        dec_valid_i <= 1'b0;
        measure(569, 244);
        while (encode_o !== 1'b1) tick();
        @(posedge clk_i);
        put_word(2'h0, pattern_word_t'({1'b0, 3'b100, 12'h2bc}));
        put_word(2'h1, pattern_word_t'({1'b0, 3'b010, 12'h071}));
        pattern_we_i <= 1'b0;
        measure(700, 113);
        while (n_dec < 17) tick();
        `CHECK("words left", 0, dq.size())
        final_report();
    end
endmodule
